// [verilog/mie_cfg.svh]
`ifndef MIE_CFG_SVH
`define MIE_CFG_SVH

// ********************************
// widths and sizes
// ********************************
`define MIE_PC_W        11
`define MIE_STACK_DEPTH 6
`define MIE_WDT_LIMIT   256
`define MIE_DMEM_DEPTH  256

// ********************************
// special data memory locations
// ********************************
`define MIE_PCL_ADDR  8'h02
`define MIE_TBLP_ADDR 8'h07

// ********************************
// apb register offsets
// ********************************
`define MIE_REG_CTRL   8'h00
`define MIE_REG_STATUS 8'h04
`define MIE_REG_ACC    8'h08
`define MIE_REG_TABLE_HIGH_REGISTER   8'h0c
`define MIE_REG_PC     8'h10

// ********************************
// control fields and reset values
// ********************************
`define MIE_CTRL_WAKE  0
`define MIE_CTRL_WDTEN 1
`define MIE_CTRL_EMI   2
`define MIE_WDTEN_RST  1'b1

// ********************************
// status fields
// ********************************
`define MIE_ST_C    0
`define MIE_ST_Z    1
`define MIE_ST_HC   2
`define MIE_ST_OV   3
`define MIE_ST_TO   4
`define MIE_ST_PD   5
`define MIE_ST_EMI  6
`define MIE_ST_HALT 7

`endif

// [verilog/mie_pkg.sv]
`include "mie_cfg.svh"

package mie_pkg;

	// ********************************
	// operations taken by the core
	// ********************************
	typedef enum logic [5:0] {
		OP_NOP, OP_ADC, OP_ADCM, OP_ADD, OP_ADDI, OP_ADDM, OP_AND, OP_ANDI, OP_ANDM,
		OP_CALL, OP_JMP, OP_CLRM, OP_SETM, OP_CLRBIT, OP_SZ, OP_SZA, OP_SZBIT, OP_SNZBIT,
		OP_SIZ, OP_SDZ, OP_SIZA, OP_DECREMENT_SKIP_TO_ACC, OP_RET, OP_RETA, OP_INTERRUPT_RETURN, OP_TABLE_READ_CURRENT_PAGE, OP_TABLE_READ_LAST_PAGE,
		OP_CLRWDT, OP_PRE1, OP_PRE2, OP_SWAP, OP_NIBBLE_SWAP_TO_ACC, OP_HALT
	} mie_op_t;

	// decoded instruction handed to the core
	typedef struct packed {
		mie_op_t                op;     // operation
		logic [7:0]             addr;   // data memory address
		logic [2:0]             bitSel; // bit index
		logic [7:0]             imm;    // immediate operand
		logic [`MIE_PC_W-1:0]   target; // jump or call target
	} mie_instr_t;

	// arithmetic flags
	typedef struct packed {
		logic ov;
		logic hc;
		logic z;
		logic c;
	} mie_flags_t;

	// adder result
	typedef struct packed {
		logic [7:0] res;
		logic       c;
		logic       hc;
		logic       ov;
	} mie_alu_t;

	// execution states
	typedef enum logic [2:0] {
		ST_RUN    = 3'b001,
		ST_SECOND = 3'b010,
		ST_HALT   = 3'b100
	} mie_state_t;

	// watchdog pre-clear history
	typedef enum logic [1:0] {
		PRE_NONE   = 2'h0,
		PRE_FIRST  = 2'h1,
		PRE_SECOND = 2'h2
	} mie_pre_t;

endpackage

// [verilog/mie_core.sv]
`timescale 1ns/1ps
`include "mie_cfg.svh"

// What this block does
// - taken skip needs two cycles, else one
// - writing program counter low takes two cycles
// - first then second pre-clear clears flags
// - repeated first pre-clear does nothing
// - repeated second pre-clear does nothing
// - watchdog clear resets counter and both flags
// - add with carry updates all four flags
// - plain add ignores carry, updates flags
// - logical and changes only zero flag
// - call pushes pc plus one, two cycles
// - byte clear writes zero, flags untouched
// - bit clear zeroes one bit only
// - table read fills high register and memory
// - skip family tests byte or bit
// - jump loads target in two cycles
// - nibble swap to memory or accumulator
// - power-down entry takes one cycle
// - no-op advances pc; byte set writes ones
// - returns pop pc; variant loads accumulator
// - power-down stops core, sets its flag
// - interrupt return sets master interrupt enable
module mie_core #(
	parameter int          STACK_DEPTH = `MIE_STACK_DEPTH,
	parameter int unsigned WDT_LIMIT   = `MIE_WDT_LIMIT
) (
	// clock and reset
	input  wire logic                 clock,
	input  wire logic                 reset,
	// apb slave
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [7:0]           paddr,
	input  wire logic [31:0]          pwdata,
	output logic [31:0]               prdata,
	output logic                      pready,
	output logic                      pslverr,
	// instruction stream
	input  wire logic                 instrValid,
	input  wire mie_pkg::mie_instr_t  instr,
	output logic                      instrReady,
	output logic [`MIE_PC_W-1:0]      pcOut,
	// program memory table port, read is combinational
	output logic                      progRdEn,
	output logic [`MIE_PC_W-1:0]      progRdAddr,
	input  wire logic [15:0]          progRdData,
	// core status
	output logic                      powerDown,
	output logic                      masterIntEnable
);

	// ********************************
	// helpers
	// ********************************

	// eight-bit add with carry in; carry, half carry and overflow out
	function automatic mie_pkg::mie_alu_t addFn(input logic [7:0] a, input logic [7:0] b, input logic cin);
		logic [8:0] s;
		logic [4:0] h;
		mie_pkg::mie_alu_t r;
		s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
		h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
		r.res = s[7:0];
		r.c = s[8];
		r.hc = h[4];
		r.ov = (a[7] == b[7]) && (s[7] != a[7]);
		return r;
	endfunction

	// ********************************
	// state
	// ********************************
	logic [7:0]             dmem [`MIE_DMEM_DEPTH];   // data memory
	logic [`MIE_PC_W-1:0]   stack [STACK_DEPTH];      // return stack
	logic [7:0]             acc_ff, nxt_acc;          // accumulator
	mie_pkg::mie_flags_t    flg_ff, nxt_flg;          // arithmetic flags
	logic [7:0]             table_high_register_ff, nxt_table_high_register;        // table high register
	logic [`MIE_PC_W-1:0]   pc_ff, nxt_pc;            // program counter
	logic [2:0]             sp_ff, nxt_sp;            // stack pointer, wraps
	mie_pkg::mie_state_t    state_ff, nxt_state;      // execution state
	mie_pkg::mie_pre_t      pre_ff, nxt_pre;          // last pre-clear seen
	logic                   emi_ff, nxt_emi;          // master interrupt enable
	logic                   to_ff, nxt_to;            // timeout flag
	logic                   pd_ff, nxt_pd;            // power-down flag
	logic [15:0]            wdt_ff, nxt_wdt;          // watchdog counter
	logic                   wdtEn_ff, nxt_wdtEn;      // watchdog run enable
	logic                   rdEn_ff, nxt_rdEn;        // table fetch pending
	logic [`MIE_PC_W-1:0]   rdAddr_ff, nxt_rdAddr;    // table fetch address
	logic [7:0]             tblDst_ff, nxt_tblDst;    // table low byte target
	logic [31:0]            prdata_ff, nxt_prdata;    // apb read data

	// ********************************
	// combinational terms
	// ********************************
	logic                   accept;     // instruction taken this cycle
	logic [7:0]             memRd;      // addressed byte
	logic [7:0]             opnd;       // memory or immediate operand
	logic [7:0]             incv;       // byte plus one
	logic [7:0]             decv;       // byte minus one
	mie_pkg::mie_alu_t      alu;        // adder result
	logic                   isSkip;     // skip family operation
	logic                   skipTaken;  // skip test passed
	logic                   memWe;      // data memory write
	logic [7:0]             memWa;      // write address
	logic [7:0]             memWd;      // write data
	logic                   stkWe;      // push
	logic                   wdtExpire;  // watchdog reaches its limit
	logic                   apbWr;      // apb write access
	logic                   mapped;     // apb address decodes

	assign accept = instrValid && instrReady;
	// the low pc byte is visible at its data address
	assign memRd = (instr.addr == `MIE_PCL_ADDR) ? pc_ff[7:0] : dmem[instr.addr];
	assign opnd = (instr.op == mie_pkg::OP_ADDI || instr.op == mie_pkg::OP_ANDI) ? instr.imm : memRd;
	assign incv = memRd + 8'h01;
	assign decv = memRd - 8'h01;
	assign isSkip = instr.op inside {mie_pkg::OP_SZ, mie_pkg::OP_SZA, mie_pkg::OP_SZBIT, mie_pkg::OP_SNZBIT,
		mie_pkg::OP_SIZ, mie_pkg::OP_SDZ, mie_pkg::OP_SIZA, mie_pkg::OP_DECREMENT_SKIP_TO_ACC};
	assign wdtExpire = wdtEn_ff && (state_ff != mie_pkg::ST_HALT) && (wdt_ff == 16'(WDT_LIMIT - 1));
	assign apbWr = psel && penable && pwrite;
	assign mapped = paddr inside {`MIE_REG_CTRL, `MIE_REG_STATUS, `MIE_REG_ACC, `MIE_REG_TABLE_HIGH_REGISTER, `MIE_REG_PC};

	// outputs: handshakes combinational, data from flops
	assign instrReady = (state_ff == mie_pkg::ST_RUN);
	assign pcOut = pc_ff;
	assign progRdEn = rdEn_ff;
	assign progRdAddr = rdAddr_ff;
	assign powerDown = (state_ff == mie_pkg::ST_HALT);
	assign masterIntEnable = emi_ff;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign prdata = prdata_ff;

	// ********************************
	// next state
	// ********************************
	always_comb
	begin
		nxt_acc = acc_ff;
		nxt_flg = flg_ff;
		nxt_table_high_register = table_high_register_ff;
		nxt_pc = pc_ff;
		nxt_sp = sp_ff;
		nxt_state = state_ff;
		nxt_pre = pre_ff;
		nxt_emi = emi_ff;
		nxt_to = to_ff;
		nxt_pd = pd_ff;
		nxt_wdtEn = wdtEn_ff;
		nxt_rdEn = 1'b0;
		nxt_rdAddr = rdAddr_ff;
		nxt_tblDst = tblDst_ff;
		nxt_prdata = prdata_ff;
		memWe = 1'b0;
		memWa = instr.addr;
		memWd = 8'h00;
		stkWe = 1'b0;
		skipTaken = 1'b0;
		alu = addFn(acc_ff, opnd, 1'b0);
		// watchdog ticks only while running; its count holds in power-down
		if (wdtExpire)
			nxt_wdt = 16'h0000;
		else if (wdtEn_ff && state_ff != mie_pkg::ST_HALT)
			nxt_wdt = wdt_ff + 16'h0001;
		else
			nxt_wdt = wdt_ff;

		// apb side: control writes and read data captured in setup
		if (apbWr && paddr == `MIE_REG_CTRL)
		begin
			nxt_wdtEn = pwdata[`MIE_CTRL_WDTEN];
			nxt_emi = pwdata[`MIE_CTRL_EMI];
			// wake-up leaves power-down with memory and registers intact
			if (pwdata[`MIE_CTRL_WAKE] && state_ff == mie_pkg::ST_HALT)
				nxt_state = mie_pkg::ST_RUN;
		end
		if (psel && !penable)
		begin
			case (paddr)
				`MIE_REG_CTRL:   nxt_prdata = {29'h0, emi_ff, wdtEn_ff, 1'b0};
				`MIE_REG_STATUS: nxt_prdata = {24'h0, powerDown, emi_ff, pd_ff, to_ff, flg_ff.ov, flg_ff.hc,
					flg_ff.z, flg_ff.c};
				`MIE_REG_ACC:    nxt_prdata = {24'h0, acc_ff};
				`MIE_REG_TABLE_HIGH_REGISTER:   nxt_prdata = {24'h0, table_high_register_ff};
				`MIE_REG_PC:     nxt_prdata = {{(32 - `MIE_PC_W){1'b0}}, pc_ff};
				default:         nxt_prdata = 32'h0000_0000;
			endcase
		end

		// second cycle: finish a pending table read
		if (state_ff == mie_pkg::ST_SECOND)
		begin
			nxt_state = mie_pkg::ST_RUN;
			if (rdEn_ff)
			begin
				memWe = 1'b1;
				memWa = tblDst_ff;
				memWd = progRdData[7:0];
				nxt_table_high_register = progRdData[15:8];
			end
		end

		if (accept)
		begin
			nxt_pc = pc_ff + 1'b1;
			// any other operation breaks a pre-clear pair
			nxt_pre = mie_pkg::PRE_NONE;
			case (instr.op)
				mie_pkg::OP_ADC, mie_pkg::OP_ADCM, mie_pkg::OP_ADD, mie_pkg::OP_ADDI, mie_pkg::OP_ADDM:
				begin
					// carry only joins the sum for the with-carry forms
					alu = addFn(acc_ff, opnd, (instr.op == mie_pkg::OP_ADC || instr.op == mie_pkg::OP_ADCM) && flg_ff.c);
					nxt_flg = '{ov: alu.ov, hc: alu.hc, z: (alu.res == 8'h00), c: alu.c};
					if (instr.op == mie_pkg::OP_ADCM || instr.op == mie_pkg::OP_ADDM)
					begin
						memWe = 1'b1;
						memWd = alu.res;
					end
					else
						nxt_acc = alu.res;
				end
				mie_pkg::OP_AND, mie_pkg::OP_ANDI, mie_pkg::OP_ANDM:
				begin
					nxt_flg.z = ((acc_ff & opnd) == 8'h00);
					if (instr.op == mie_pkg::OP_ANDM)
					begin
						memWe = 1'b1;
						memWd = acc_ff & opnd;
					end
					else
						nxt_acc = acc_ff & opnd;
				end
				mie_pkg::OP_CALL:
				begin
					stkWe = 1'b1;
					nxt_sp = sp_ff + 3'h1;
					nxt_pc = instr.target;
					nxt_state = mie_pkg::ST_SECOND;
				end
				mie_pkg::OP_JMP:
				begin
					nxt_pc = instr.target;
					nxt_state = mie_pkg::ST_SECOND;
				end
				mie_pkg::OP_CLRM:
					memWe = 1'b1;
				mie_pkg::OP_SETM:
				begin
					memWe = 1'b1;
					memWd = 8'hff;
				end
				mie_pkg::OP_CLRBIT:
				begin
					memWe = 1'b1;
					memWd = memRd & ~(8'h01 << instr.bitSel);
				end
				mie_pkg::OP_SZ, mie_pkg::OP_SZA:
				begin
					skipTaken = (memRd == 8'h00);
					if (instr.op == mie_pkg::OP_SZA)
						nxt_acc = memRd;
				end
				mie_pkg::OP_SZBIT:
					skipTaken = !memRd[instr.bitSel];
				mie_pkg::OP_SNZBIT:
					skipTaken = memRd[instr.bitSel];
				mie_pkg::OP_SIZ, mie_pkg::OP_SIZA:
				begin
					skipTaken = (incv == 8'h00);
					if (instr.op == mie_pkg::OP_SIZA)
						nxt_acc = incv;
					else
					begin
						memWe = 1'b1;
						memWd = incv;
					end
				end
				mie_pkg::OP_SDZ, mie_pkg::OP_DECREMENT_SKIP_TO_ACC:
				begin
					skipTaken = (decv == 8'h00);
					if (instr.op == mie_pkg::OP_DECREMENT_SKIP_TO_ACC)
						nxt_acc = decv;
					else
					begin
						memWe = 1'b1;
						memWd = decv;
					end
				end
				mie_pkg::OP_RET, mie_pkg::OP_RETA, mie_pkg::OP_INTERRUPT_RETURN:
				begin
					nxt_sp = sp_ff - 3'h1;
					nxt_pc = stack[sp_ff - 3'h1];
					nxt_state = mie_pkg::ST_SECOND;
					if (instr.op == mie_pkg::OP_RETA)
						nxt_acc = instr.imm;
				end
				mie_pkg::OP_TABLE_READ_CURRENT_PAGE, mie_pkg::OP_TABLE_READ_LAST_PAGE:
				begin
					// pointer byte sits in data memory; page is current or last
					nxt_rdEn = 1'b1;
					nxt_rdAddr = (instr.op == mie_pkg::OP_TABLE_READ_CURRENT_PAGE) ?
						{pc_ff[`MIE_PC_W-1:8], dmem[`MIE_TBLP_ADDR]} :
						{{(`MIE_PC_W - 8){1'b1}}, dmem[`MIE_TBLP_ADDR]};
					nxt_tblDst = instr.addr;
					nxt_state = mie_pkg::ST_SECOND;
				end
				mie_pkg::OP_CLRWDT:
				begin
					nxt_wdt = 16'h0000;
					nxt_to = 1'b0;
					nxt_pd = 1'b0;
				end
				mie_pkg::OP_PRE1, mie_pkg::OP_PRE2:
				begin
					// the two halves must alternate to take effect
					if ((instr.op == mie_pkg::OP_PRE1 && pre_ff == mie_pkg::PRE_SECOND) ||
						(instr.op == mie_pkg::OP_PRE2 && pre_ff == mie_pkg::PRE_FIRST))
					begin
						nxt_wdt = 16'h0000;
						nxt_to = 1'b0;
						nxt_pd = 1'b0;
					end
					else
						nxt_pre = (instr.op == mie_pkg::OP_PRE1) ? mie_pkg::PRE_FIRST : mie_pkg::PRE_SECOND;
				end
				mie_pkg::OP_SWAP:
				begin
					memWe = 1'b1;
					memWd = {memRd[3:0], memRd[7:4]};
				end
				mie_pkg::OP_NIBBLE_SWAP_TO_ACC:
					nxt_acc = {memRd[3:0], memRd[7:4]};
				mie_pkg::OP_HALT:
				begin
					nxt_wdt = 16'h0000;
					nxt_to = 1'b0;
					nxt_pd = 1'b1;
					nxt_state = mie_pkg::ST_HALT;
				end
				default:
				begin
					// no-op and unused codes only advance the pc
				end
			endcase
			if (skipTaken)
			begin
				nxt_pc = pc_ff + 2'd2;
				nxt_state = mie_pkg::ST_SECOND;
			end
			// a write to the low pc byte redirects and costs a second cycle
			if (memWe && memWa == `MIE_PCL_ADDR)
			begin
				nxt_pc = {pc_ff[`MIE_PC_W-1:8], memWd};
				nxt_state = mie_pkg::ST_SECOND;
			end
			if (instr.op == mie_pkg::OP_INTERRUPT_RETURN)
				nxt_emi = 1'b1;
		end
		// a timeout in the same cycle as a clear is not lost
		if (wdtExpire)
			nxt_to = 1'b1;
	end

	// ********************************
	// registers
	// ********************************
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			acc_ff <= 8'h00;
			flg_ff <= '0;
			table_high_register_ff <= 8'h00;
			pc_ff <= '0;
			sp_ff <= 3'h0;
			state_ff <= mie_pkg::ST_RUN;
			pre_ff <= mie_pkg::PRE_NONE;
			emi_ff <= 1'b0;
			to_ff <= 1'b0;
			pd_ff <= 1'b0;
			wdt_ff <= 16'h0000;
			wdtEn_ff <= `MIE_WDTEN_RST;
			rdEn_ff <= 1'b0;
			rdAddr_ff <= '0;
			tblDst_ff <= 8'h00;
			prdata_ff <= 32'h0000_0000;
		end
		else
		begin
			acc_ff <= nxt_acc;
			flg_ff <= nxt_flg;
			table_high_register_ff <= nxt_table_high_register;
			pc_ff <= nxt_pc;
			sp_ff <= (nxt_sp == 3'(STACK_DEPTH)) ? 3'h0 : nxt_sp;
			state_ff <= nxt_state;
			pre_ff <= nxt_pre;
			emi_ff <= nxt_emi;
			to_ff <= nxt_to;
			pd_ff <= nxt_pd;
			wdt_ff <= nxt_wdt;
			wdtEn_ff <= nxt_wdtEn;
			rdEn_ff <= nxt_rdEn;
			rdAddr_ff <= nxt_rdAddr;
			tblDst_ff <= nxt_tblDst;
			prdata_ff <= nxt_prdata;
		end
	end

	// memories carry no reset, their contents are undefined at power-up
	always_ff @(posedge clock)
	begin
		if (memWe && memWa != `MIE_PCL_ADDR)
			dmem[memWa] <= memWd;
		if (stkWe)
			stack[sp_ff] <= pc_ff + 1'b1;
	end

	// ********************************
	// checks
	// ********************************
	skip_taken_a: assert property (@(posedge clock) disable iff (reset)
		accept && isSkip && skipTaken && !(memWe && memWa == `MIE_PCL_ADDR) |=>
		!instrReady ##1 instrReady && pcOut == $past(pcOut, 2) + 2'd2)
		else $error("taken skip did not take two cycles");
	skip_none_a: assert property (@(posedge clock) disable iff (reset)
		accept && isSkip && !skipTaken && !(memWe && memWa == `MIE_PCL_ADDR) |=> instrReady)
		else $error("untaken skip stalled");
	pcl_write_a: assert property (@(posedge clock) disable iff (reset)
		accept && memWe && memWa == `MIE_PCL_ADDR |=> !instrReady && pcOut[7:0] == $past(memWd))
		else $error("pc low write not two cycles");
	pre_pair_a: assert property (@(posedge clock) disable iff (reset)
		accept && instr.op == mie_pkg::OP_PRE2 && pre_ff == mie_pkg::PRE_FIRST && !wdtExpire |=> !to_ff && !pd_ff)
		else $error("pre-clear pair did not clear flags");
	pre_first_a: assert property (@(posedge clock) disable iff (reset)
		accept && instr.op == mie_pkg::OP_PRE1 && pre_ff != mie_pkg::PRE_SECOND && !wdtExpire |=> $stable(to_ff) && $stable(pd_ff))
		else $error("lone first pre-clear changed flags");
	pre_second_a: assert property (@(posedge clock) disable iff (reset)
		accept && instr.op == mie_pkg::OP_PRE2 && pre_ff != mie_pkg::PRE_FIRST && !wdtExpire |=> $stable(to_ff) && $stable(pd_ff))
		else $error("lone second pre-clear changed flags");
	wdt_clear_a: assert property (@(posedge clock) disable iff (reset)
		accept && instr.op == mie_pkg::OP_CLRWDT && !wdtExpire |=> wdt_ff == 16'h0000 && !to_ff && !pd_ff && instrReady)
		else $error("watchdog clear incomplete");
	call_flow_a: assert property (@(posedge clock) disable iff (reset)
		accept && instr.op == mie_pkg::OP_CALL |=> pcOut == $past(instr.target) && $stable(flg_ff) && !instrReady ##1 instrReady)
		else $error("call did not load target in two cycles");
	halt_entry_a: assert property (@(posedge clock) disable iff (reset)
		accept && instr.op == mie_pkg::OP_HALT && !wdtExpire |=> powerDown && pd_ff && !to_ff && wdt_ff == 16'h0000)
		else $error("power-down entry wrong");
	interrupt_return_emi_a: assert property (@(posedge clock) disable iff (reset)
		accept && instr.op == mie_pkg::OP_INTERRUPT_RETURN |=> masterIntEnable)
		else $error("interrupt return left enable clear");

endmodule

// [verif/mie_prog_model.sv]
`timescale 1ns/1ps
`include "mie_cfg.svh"

// ********************************
// program memory behind the table port
// ********************************
module mie_prog_model (
	// clock
	input  wire logic                 clock,
	// table port
	input  wire logic                 progRdEn,
	input  wire logic [`MIE_PC_W-1:0] progRdAddr,
	output logic      [15:0]          progRdData
);
	logic [15:0] idleMix = 16'h0000; // moving filler, never the last word

	// filler changes every cycle so a late sample cannot pass by luck
	always_ff @(posedge clock)
		idleMix <= ~idleMix + 16'h3b1d;

	// word is a fixed mix of its address, so the bench can predict both bytes
	always_comb
		progRdData = progRdEn ? {~progRdAddr[7:0], progRdAddr[7:0] ^ {progRdAddr[10:8], 5'h0a}} : idleMix;
endmodule

// [verif/mcu_instruction_execute_tb.sv]
`timescale 1ns/1ps
`include "mie_cfg.svh"

module mcu_instruction_execute_tb;
	// ********************************
	// stimulus, model state, counters
	// ********************************
	logic                clock = 1'b0;
	logic                reset = 1'b1;
	logic                psel = 1'b0, penable = 1'b0, pwrite = 1'b0, instrValid = 1'b0;
	logic [7:0]          paddr = 8'h00, x, y, m, p, mv, lo;
	logic [31:0]         pwdata = 32'h0, prdata, lfsr = 32'h6f6b;
	logic                pready, pslverr, instrReady, progRdEn, powerDown, masterIntEnable;
	mie_pkg::mie_instr_t instr = '0;
	logic [10:0]         pcOut, progRdAddr, mPc = 11'h000;
	logic [15:0]         progRdData;
	logic [32:0]         expQ[$];        // {pslverr, prdata} notes
	logic [10:0]         stk[$];         // return addresses
	logic [7:0]          mAcc = 8'h00;   // accumulator model
	logic [3:0]          mF = 4'h0;      // ov hc z c
	logic                mTo = 1'b0, mPd = 1'b0, mEmi = 1'b0, mPw = 1'b0;
	int                  mismatches = 0, samples_checked = 0;

	always #50 clock = ~clock;

	mie_core #(.WDT_LIMIT(16)) u_dut (.clock, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .instrValid, .instr, .instrReady, .pcOut, .progRdEn, .progRdAddr, .progRdData,
		.powerDown, .masterIntEnable);
	mie_prog_model u_prog (.clock, .progRdEn, .progRdAddr, .progRdData);

	// ********************************
	// helpers
	// ********************************
	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic results;
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// add model; flags land in mF, sum is returned
	function automatic logic [7:0] add(input logic [7:0] b, input logic ci);
		logic [8:0] s;
		s = mAcc + b + ci;
		mF = {(mAcc[7] == b[7]) && (s[7] != mAcc[7]), ({1'b0, mAcc[3:0]} + b[3:0] + ci) > 5'h0f, s[7:0] == 8'h00, s[8]};
		return s[7:0];
	endfunction

	function automatic logic [32:0] st();
		return {25'h0, mPw, mEmi, mPd, mTo, mF};
	endfunction

	// next value of the random source
	function automatic logic [31:0] lfsrNext(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction

	// apb master: request held until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		while (pready !== 1'b1)
			@(posedge clock);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask

	// a read leaves its expectation for the watcher
	task automatic rd(input logic [7:0] a, input logic [32:0] e);
		expQ.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask

	// offer one instruction; keep leaves valid up for a back-to-back partner
	task automatic ex(input mie_pkg::mie_op_t o, input logic [7:0] a, input logic [7:0] i, input logic gap,
		input logic keep = 1'b0);
		instr <= '{op: o, addr: a, bitSel: i[2:0], imm: i, target: {a[2:0], i}};
		instrValid <= 1'b1;
		@(posedge clock);
		while (instrReady !== 1'b1)
			@(posedge clock);
		if (o == mie_pkg::OP_CALL)
			stk.push_back(mPc + 11'd1);
		mPc = (o inside {mie_pkg::OP_CALL, mie_pkg::OP_JMP}) ? {a[2:0], i} :
			(o inside {mie_pkg::OP_RET, mie_pkg::OP_RETA, mie_pkg::OP_INTERRUPT_RETURN}) ? stk.pop_back() :
			(o == mie_pkg::OP_CLRM && a == `MIE_PCL_ADDR) ? {mPc[10:8], 8'h00} :
			mPc + ((gap && o inside {[mie_pkg::OP_SZ:mie_pkg::OP_DECREMENT_SKIP_TO_ACC]}) ? 11'd2 : 11'd1);
		if (keep)
			return;
		instrValid <= 1'b0;
		@(posedge clock);
		check({32'h0, instrReady}, {32'h0, !gap});
		check({22'h0, pcOut}, {22'h0, mPc});
	endtask

	// watcher: each completed read takes the oldest note
	always @(posedge clock)
		if (psel && penable && pready && !pwrite)
			check({pslverr, prdata}, expQ.pop_front());

	// ********************************
	// main sequence
	// ********************************
	initial
	begin
		repeat (20) @(posedge clock);
		reset <= 1'b0;
		@(posedge clock);
		// reset values; watchdog stopped so flags stay predictable
		rd(`MIE_REG_CTRL, 33'h2);
		apb(1'b1, `MIE_REG_CTRL, 32'h0);
		rd(`MIE_REG_STATUS, st());
		apb(1'b1, `MIE_REG_ACC, 32'hff);
		rd(`MIE_REG_ACC, 33'h0);
		rd(8'h14, 33'h1_0000_0000);
		// random arithmetic and logic
		repeat (6)
		begin
			lfsr = lfsrNext(lfsr);
			x = lfsr[7:0];
			y = lfsr[15:8];
			m = {2'b01, lfsr[21:16]};
			ex(mie_pkg::OP_ANDI, 8'h00, 8'h00, 1'b0);
			mAcc = 8'h00;
			mF[1] = 1'b1;
			ex(mie_pkg::OP_ADDI, 8'h00, x, 1'b0);
			mAcc = add(x, 1'b0);
			ex(mie_pkg::OP_CLRM, m, 8'h00, 1'b0);
			ex(mie_pkg::OP_ADDM, m, 8'h00, 1'b0);
			mv = add(8'h00, 1'b0);
			ex(mie_pkg::OP_ADDI, 8'h00, y, 1'b0);
			mAcc = add(y, 1'b0);
			ex(mie_pkg::OP_ADC, m, 8'h00, 1'b0);
			mAcc = add(mv, mF[0]);
			rd(`MIE_REG_STATUS, st());
			ex(mie_pkg::OP_ADD, m, 8'h00, 1'b0);
			mAcc = add(mv, 1'b0);
			ex(mie_pkg::OP_ADCM, m, 8'h00, 1'b0);
			mv = add(mv, mF[0]);
			ex(mie_pkg::OP_AND, m, 8'h00, 1'b0);
			mAcc = mAcc & mv;
			mF[1] = (mAcc == 8'h00);
			rd(`MIE_REG_STATUS, st());
			ex(mie_pkg::OP_SZA, m, 8'h00, mv == 8'h00);
			mAcc = mv;
			rd(`MIE_REG_ACC, {25'h0, mAcc});
		end
		// skip family, bit clear, swap, set, no-op
		ex(mie_pkg::OP_JMP, 8'h01, 8'h23, 1'b1);
		rd(`MIE_REG_PC, {22'h0, mPc});
		ex(mie_pkg::OP_CLRM, 8'h20, 8'h00, 1'b0);
		ex(mie_pkg::OP_SZ, 8'h20, 8'h00, 1'b1);
		ex(mie_pkg::OP_SETM, 8'h20, 8'h00, 1'b0);
		ex(mie_pkg::OP_SZ, 8'h20, 8'h00, 1'b0);
		ex(mie_pkg::OP_SIZ, 8'h20, 8'h00, 1'b1);
		ex(mie_pkg::OP_SDZ, 8'h20, 8'h00, 1'b0);
		ex(mie_pkg::OP_DECREMENT_SKIP_TO_ACC, 8'h20, 8'h00, 1'b0);
		ex(mie_pkg::OP_CLRBIT, 8'h20, 8'h00, 1'b0);
		ex(mie_pkg::OP_SZBIT, 8'h20, 8'h00, 1'b1);
		ex(mie_pkg::OP_SNZBIT, 8'h20, 8'h00, 1'b0);
		ex(mie_pkg::OP_SNZBIT, 8'h20, 8'h01, 1'b1);
		ex(mie_pkg::OP_SWAP, 8'h20, 8'h00, 1'b0);
		ex(mie_pkg::OP_NIBBLE_SWAP_TO_ACC, 8'h20, 8'h00, 1'b0);
		ex(mie_pkg::OP_SIZA, 8'h20, 8'h00, 1'b0);
		ex(mie_pkg::OP_NOP, 8'h00, 8'h00, 1'b0);
		rd(`MIE_REG_ACC, 33'hf0);
		rd(`MIE_REG_PC, {22'h0, mPc});
		rd(`MIE_REG_STATUS, st());
		ex(mie_pkg::OP_SZA, 8'h20, 8'h00, 1'b0);
		rd(`MIE_REG_ACC, 33'hef);
		ex(mie_pkg::OP_CLRM, `MIE_PCL_ADDR, 8'h00, 1'b1);
		rd(`MIE_REG_PC, {22'h0, mPc});
		// nested calls and the three returns
		ex(mie_pkg::OP_CALL, 8'h04, 8'h56, 1'b1);
		rd(`MIE_REG_PC, {22'h0, mPc});
		ex(mie_pkg::OP_CALL, 8'h05, 8'h00, 1'b1);
		ex(mie_pkg::OP_RETA, 8'h00, 8'h3c, 1'b1);
		mAcc = 8'h3c;
		rd(`MIE_REG_PC, {22'h0, mPc});
		rd(`MIE_REG_ACC, {25'h0, mAcc});
		ex(mie_pkg::OP_RET, 8'h00, 8'h00, 1'b1);
		ex(mie_pkg::OP_CALL, 8'h06, 8'h77, 1'b1);
		ex(mie_pkg::OP_INTERRUPT_RETURN, 8'h00, 8'h00, 1'b1);
		mEmi = 1'b1;
		rd(`MIE_REG_PC, {22'h0, mPc});
		rd(`MIE_REG_STATUS, st());
		check({32'h0, masterIntEnable}, 33'h1);
		// table reads, current page then last page
		p = lfsr[31:24];
		ex(mie_pkg::OP_JMP, 8'h05, 8'h10, 1'b1);
		ex(mie_pkg::OP_ANDI, 8'h00, 8'h00, 1'b0);
		mAcc = 8'h00;
		mF[1] = 1'b1;
		ex(mie_pkg::OP_ADDI, 8'h00, p, 1'b0);
		mAcc = add(p, 1'b0);
		ex(mie_pkg::OP_CLRM, `MIE_TBLP_ADDR, 8'h00, 1'b0);
		ex(mie_pkg::OP_ADDM, `MIE_TBLP_ADDR, 8'h00, 1'b0);
		mv = add(8'h00, 1'b0);
		for (int k = 0; k < 2; k++)
		begin
			ex(k ? mie_pkg::OP_TABLE_READ_LAST_PAGE : mie_pkg::OP_TABLE_READ_CURRENT_PAGE, 8'h30, 8'h00, 1'b1);
			lo = p ^ {k ? 3'h7 : 3'h5, 5'h0a};
			ex(mie_pkg::OP_SZA, 8'h30, 8'h00, lo == 8'h00);
			mAcc = lo;
			rd(`MIE_REG_TABLE_HIGH_REGISTER, {25'h0, ~p});
			rd(`MIE_REG_ACC, {25'h0, mAcc});
		end
		// watchdog runs out, then pre-clear pairs good and bad
		apb(1'b1, `MIE_REG_CTRL, 32'h2);
		mEmi = 1'b0; // control write drops the enable too
		repeat (50) @(posedge clock);
		apb(1'b1, `MIE_REG_CTRL, 32'h0);
		mTo = 1'b1;
		ex(mie_pkg::OP_PRE1, 8'h00, 8'h00, 1'b0, 1'b1);
		ex(mie_pkg::OP_PRE1, 8'h00, 8'h00, 1'b0);
		ex(mie_pkg::OP_NOP, 8'h00, 8'h00, 1'b0);
		ex(mie_pkg::OP_PRE2, 8'h00, 8'h00, 1'b0, 1'b1);
		ex(mie_pkg::OP_PRE2, 8'h00, 8'h00, 1'b0);
		rd(`MIE_REG_STATUS, st());
		ex(mie_pkg::OP_NOP, 8'h00, 8'h00, 1'b0);
		ex(mie_pkg::OP_PRE1, 8'h00, 8'h00, 1'b0, 1'b1);
		ex(mie_pkg::OP_PRE2, 8'h00, 8'h00, 1'b0);
		mTo = 1'b0;
		rd(`MIE_REG_STATUS, st());
		// power-down, wake, then single-step clear of both flags
		ex(mie_pkg::OP_HALT, 8'h00, 8'h00, 1'b1);
		{mPw, mPd} = 2'b11;
		check({32'h0, powerDown}, 33'h1);
		rd(`MIE_REG_STATUS, st());
		apb(1'b1, `MIE_REG_CTRL, 32'h3);
		mPw = 1'b0;
		repeat (50) @(posedge clock);
		apb(1'b1, `MIE_REG_CTRL, 32'h0);
		mTo = 1'b1;
		rd(`MIE_REG_STATUS, st());
		ex(mie_pkg::OP_CLRWDT, 8'h00, 8'h00, 1'b0);
		{mTo, mPd} = 2'b00;
		rd(`MIE_REG_STATUS, st());
		results();
	end

	// hang guard, far beyond the few hundred cycles the run needs
	initial
	begin
		repeat (20000) @(posedge clock);
		mismatches++;
		results();
	end
endmodule
